// [logic/timer_channel_compare_control.sv]
// one capture/compare channel of a simple timer with its register file
// What this block does
// - preload off: compare write goes straight to the active comparator value
// - preload on: written value waits, copied to active value on update event
// - mode 000 holds, 001 clears, 010 sets, 011 toggles reference on match
// - mode 100 forces reference to 0, mode 101 forces it to 1
// - mode 110: reference active while counter below compare value
// - mode 111: reference inactive while counter below compare value
// - input mode: channel enable switches input capture on and off
// - output mode: enable drives channel output to pin, otherwise inactive
// - input polarity 0 captures rising edge, 1 captures falling edge
// - output polarity 0 active high, 1 active low
// - interrupt enable bit 10 gates trigger event interrupt
// - interrupt enable bit 8 gates update event interrupt
// - interrupt enable bit 0 gates channel capture/compare interrupt
// - mode select 00 output, 01 or 11 input, 10 reserved
// - clearing channel enable resets capture event prescaler
// - update event from overflow, software request or restart trigger
// - trigger flag set by hardware, held until software clears it
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "timer_channel_defs.svh"
module timer_channel_compare_control
  import timer_channel_pkg::*;
#(
  parameter int COUNTER_W = `COUNTER_W
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [COUNTER_W-1:0] counter_value_i,
  input  wire logic                 counter_wrap_i,
  input  wire logic                 restart_trigger_i,
  input  wire logic                 trigger_i,
  input  wire logic                 channel_in_i,
  output logic                      channel_out_o,
  output logic                      channel_out_en_o,
  output logic                      capture_enable_o,
  output logic                      update_event_o,
  output logic                      irq_o
);

  // register fields
  logic [1:0]           channel_mode_select;
  logic [1:0]           capture_input_prescaler;
  logic                 compare_preload_enable;
  logic [2:0]           output_mode_field;
  logic                 channel_enable;
  logic                 channel_polarity;
  logic                 trigger_irq_enable;
  logic                 update_irq_enable;
  logic                 channel_irq_enable;
  logic                 trigger_event_flag;
  logic                 update_event_flag;
  logic                 over_capture_flag;
  logic                 channel_event_flag;
  logic                 output_reference;
  logic                 match_prev;
  logic                 in_meta;
  logic                 in_sync;

  logic [1:0]           next_channel_mode_select;
  logic [1:0]           next_capture_input_prescaler;
  logic                 next_compare_preload_enable;
  logic [2:0]           next_output_mode_field;
  logic                 next_channel_enable;
  logic                 next_channel_polarity;
  logic                 next_trigger_irq_enable;
  logic                 next_update_irq_enable;
  logic                 next_channel_irq_enable;
  logic                 next_trigger_event_flag;
  logic                 next_update_event_flag;
  logic                 next_over_capture_flag;
  logic                 next_channel_event_flag;
  logic                 next_output_reference;
  logic                 next_match_prev;
  logic [31:0]          next_wb_dat;
  logic                 next_wb_ack;
  logic                 next_channel_out;
  logic                 next_channel_out_en;
  logic                 next_capture_enable;
  logic                 next_update_event;
  logic                 next_irq;

  logic                 access;
  logic                 wr;
  logic                 rd;
  logic [31:0]          wmask;
  logic [31:0]          wval;
  logic                 is_output;
  logic                 is_input;
  logic                 sw_update;
  logic                 sw_trigger;
  logic                 sw_channel;
  logic                 update_now;
  logic                 trigger_now;
  logic                 match_now;
  logic                 new_match;
  logic                 below;
  logic                 capture_pulse;
  logic                 channel_set;
  logic                 compare_write;
  logic [COUNTER_W-1:0] compare_preload;
  logic [COUNTER_W-1:0] compare_active;
  output_mode_e         mode;

  // bus request decode: a write or read completes at the edge where ack is high
  always_comb
  begin
    access        = wb_cyc_i & wb_stb_i & wb_ack_o;
    wr            = access & wb_we_i;
    rd            = access & ~wb_we_i;
    wmask         = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wval          = wb_dat_i & wmask;
    is_output     = (channel_mode_select == SEL_OUTPUT);
    is_input      = (channel_mode_select == SEL_INPUT_TI) ||
                    (channel_mode_select == SEL_INPUT_ED);
    sw_update     = wr && (wb_adr_i == `OFS_EVENT_GENERATE) && wval[`BIT_UPDATE];
    sw_trigger    = wr && (wb_adr_i == `OFS_EVENT_GENERATE) && wval[`BIT_TRIGGER];
    sw_channel    = wr && (wb_adr_i == `OFS_EVENT_GENERATE) && wval[`BIT_CHANNEL];
    update_now    = counter_wrap_i | sw_update | restart_trigger_i;
    trigger_now   = trigger_i | sw_trigger;
    compare_write = wr && (wb_adr_i == `OFS_COMPARE_VALUE);
    match_now     = (counter_value_i == compare_active);
    new_match     = match_now & ~match_prev;
    below         = (counter_value_i < compare_active);
    mode          = output_mode_e'(output_mode_field);
    channel_set   = (is_output & new_match) | (is_input & capture_pulse) | sw_channel;
  end

  // channel input pin passes two flip-flops before the edge logic
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
    end
    else
    begin
      in_meta <= channel_in_i;
      in_sync <= in_meta;
    end
  end

  capture_edge_prescaler u_capture (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .level_i    (in_sync),
    .falling_i  (channel_polarity),
    .enable_i   (channel_enable & is_input),
    .prescale_i (capture_input_prescaler),
    .capture_o  (capture_pulse)
  );

  compare_shadow #(
    .WIDTH (COUNTER_W)
  ) u_compare (
    .sys_clk_i        (sys_clk_i),
    .rst_i            (rst_i),
    .write_i          (compare_write),
    .write_data_i     (wval[COUNTER_W-1:0]),
    .preload_enable_i (compare_preload_enable),
    .update_i         (update_now),
    .capture_i        ((is_input & capture_pulse) | (is_input & sw_channel)),
    .capture_data_i   (counter_value_i),
    .preload_o        (compare_preload),
    .active_o         (compare_active)
  );

  // register writes, flags and output reference
  always_comb
  begin
    next_channel_mode_select     = channel_mode_select;
    next_capture_input_prescaler = capture_input_prescaler;
    next_compare_preload_enable  = compare_preload_enable;
    next_output_mode_field       = output_mode_field;
    next_channel_enable          = channel_enable;
    next_channel_polarity        = channel_polarity;
    next_trigger_irq_enable      = trigger_irq_enable;
    next_update_irq_enable       = update_irq_enable;
    next_channel_irq_enable      = channel_irq_enable;
    next_trigger_event_flag      = trigger_event_flag;
    next_update_event_flag       = update_event_flag;
    next_over_capture_flag       = over_capture_flag;
    next_channel_event_flag      = channel_event_flag;
    next_match_prev              = match_now;
    next_output_reference        = output_reference;
    if (wr)
    begin
      case (wb_adr_i)
        `OFS_INPUT_CONFIG:
        begin
          if (!channel_enable && wb_sel_i[2])
            next_channel_mode_select = wval[`BIT_MODE_SELECT_LO +: 2];
          if (wb_sel_i[2])
            next_capture_input_prescaler = wval[`BIT_PRESCALER_LO +: 2];
        end
        `OFS_OUTPUT_CONFIG:
        begin
          if (wb_sel_i[0])
          begin
            next_compare_preload_enable = wval[`BIT_PRELOAD_ENABLE];
            next_output_mode_field      = wval[`BIT_OUTPUT_MODE_LO +: 3];
          end
        end
        `OFS_ENABLE_CONTROL:
          if (wb_sel_i[0])
            next_channel_enable = wval[`BIT_CHANNEL_ENABLE];
        `OFS_POLARITY_CONFIG:
          if (wb_sel_i[0])
            next_channel_polarity = wval[`BIT_CHANNEL_POLARITY];
        `OFS_IRQ_ENABLE:
        begin
          if (wb_sel_i[1])
          begin
            next_trigger_irq_enable = wval[`BIT_TRIGGER];
            next_update_irq_enable  = wval[`BIT_UPDATE];
          end
          if (wb_sel_i[0])
            next_channel_irq_enable = wval[`BIT_CHANNEL];
        end
        `OFS_EVENT_STATUS:
        begin
          if (wb_sel_i[1] && !wb_dat_i[`BIT_TRIGGER])
            next_trigger_event_flag = 1'b0;
          if (wb_sel_i[1] && !wb_dat_i[`BIT_UPDATE])
            next_update_event_flag = 1'b0;
          if (wb_sel_i[0] && !wb_dat_i[`BIT_OVER_CAPTURE])
            next_over_capture_flag = 1'b0;
          if (wb_sel_i[0] && !wb_dat_i[`BIT_CHANNEL])
            next_channel_event_flag = 1'b0;
        end
        default:
          next_channel_enable = channel_enable;
      endcase
    end
    if (rd && is_input && (wb_adr_i == `OFS_COMPARE_VALUE))
      next_channel_event_flag = 1'b0;
    // hardware set wins over a clear in the same cycle
    if (trigger_now)
      next_trigger_event_flag = 1'b1;
    if (update_now)
      next_update_event_flag = 1'b1;
    if (is_input && capture_pulse && channel_event_flag)
      next_over_capture_flag = 1'b1;
    if (channel_set)
      next_channel_event_flag = 1'b1;
    case (mode)
      MODE_HOLD:      next_output_reference = output_reference;
      MODE_MATCH_LOW: if (new_match) next_output_reference = 1'b0;
      MODE_MATCH_HI:  if (new_match) next_output_reference = 1'b1;
      MODE_TOGGLE:    if (new_match) next_output_reference = ~output_reference;
      MODE_FORCE_LOW: next_output_reference = 1'b0;
      MODE_FORCE_HI:  next_output_reference = 1'b1;
      MODE_PWM_ONE:   next_output_reference = below;
      MODE_PWM_TWO:   next_output_reference = ~below;
      default:        next_output_reference = output_reference;
    endcase
  end

  // registered outputs
  always_comb
  begin
    next_channel_out_en = channel_enable & is_output;
    if (channel_enable && is_output)
      next_channel_out = next_output_reference ^ channel_polarity;
    else
      next_channel_out = channel_polarity;
    next_capture_enable = channel_enable & is_input;
    next_update_event   = update_now;
    next_irq            = (next_trigger_event_flag & next_trigger_irq_enable) |
                          (next_update_event_flag & next_update_irq_enable) |
                          (next_channel_event_flag & next_channel_irq_enable);
    next_wb_ack         = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_wb_dat         = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_INPUT_CONFIG:
      begin
        next_wb_dat[`BIT_MODE_SELECT_LO +: 2] = channel_mode_select;
        next_wb_dat[`BIT_PRESCALER_LO +: 2]   = capture_input_prescaler;
      end
      `OFS_OUTPUT_CONFIG:
      begin
        next_wb_dat[`BIT_PRELOAD_ENABLE]     = compare_preload_enable;
        next_wb_dat[`BIT_OUTPUT_MODE_LO +: 3] = output_mode_field;
      end
      `OFS_ENABLE_CONTROL:
        next_wb_dat[`BIT_CHANNEL_ENABLE] = channel_enable;
      `OFS_POLARITY_CONFIG:
        next_wb_dat[`BIT_CHANNEL_POLARITY] = channel_polarity;
      `OFS_IRQ_ENABLE:
      begin
        next_wb_dat[`BIT_TRIGGER] = trigger_irq_enable;
        next_wb_dat[`BIT_UPDATE]  = update_irq_enable;
        next_wb_dat[`BIT_CHANNEL] = channel_irq_enable;
      end
      `OFS_EVENT_STATUS:
      begin
        next_wb_dat[`BIT_TRIGGER]      = trigger_event_flag;
        next_wb_dat[`BIT_UPDATE]       = update_event_flag;
        next_wb_dat[`BIT_OVER_CAPTURE] = over_capture_flag;
        next_wb_dat[`BIT_CHANNEL]      = channel_event_flag;
      end
      `OFS_COMPARE_VALUE:
        next_wb_dat[COUNTER_W-1:0] = compare_preload;
      default:
        next_wb_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      channel_mode_select     <= 2'h0;
      capture_input_prescaler <= 2'h0;
      compare_preload_enable  <= 1'b0;
      output_mode_field       <= 3'h0;
      channel_enable          <= 1'b0;
      channel_polarity        <= 1'b0;
      trigger_irq_enable      <= 1'b0;
      update_irq_enable       <= 1'b0;
      channel_irq_enable      <= 1'b0;
      trigger_event_flag      <= 1'b0;
      update_event_flag       <= 1'b0;
      over_capture_flag       <= 1'b0;
      channel_event_flag      <= 1'b0;
      output_reference        <= 1'b0;
      match_prev              <= 1'b0;
      wb_dat_o                <= `RESET_REGISTER;
      wb_ack_o                <= 1'b0;
      channel_out_o           <= 1'b0;
      channel_out_en_o        <= 1'b0;
      capture_enable_o        <= 1'b0;
      update_event_o          <= 1'b0;
      irq_o                   <= 1'b0;
    end
    else
    begin
      channel_mode_select     <= next_channel_mode_select;
      capture_input_prescaler <= next_capture_input_prescaler;
      compare_preload_enable  <= next_compare_preload_enable;
      output_mode_field       <= next_output_mode_field;
      channel_enable          <= next_channel_enable;
      channel_polarity        <= next_channel_polarity;
      trigger_irq_enable      <= next_trigger_irq_enable;
      update_irq_enable       <= next_update_irq_enable;
      channel_irq_enable      <= next_channel_irq_enable;
      trigger_event_flag      <= next_trigger_event_flag;
      update_event_flag       <= next_update_event_flag;
      over_capture_flag       <= next_over_capture_flag;
      channel_event_flag      <= next_channel_event_flag;
      output_reference        <= next_output_reference;
      match_prev              <= next_match_prev;
      wb_dat_o                <= next_wb_dat;
      wb_ack_o                <= next_wb_ack;
      channel_out_o           <= next_channel_out;
      channel_out_en_o        <= next_channel_out_en;
      capture_enable_o        <= next_capture_enable;
      update_event_o          <= next_update_event;
      irq_o                   <= next_irq;
    end
  end

endmodule

// [logic/timer_channel_defs.svh]
// register offsets, field positions, reset values and sizes of the timer channel
`ifndef TIMER_CHANNEL_DEFS_SVH
`define TIMER_CHANNEL_DEFS_SVH

`define ADDR_W                 8
`define OFS_INPUT_CONFIG       8'h20
`define OFS_OUTPUT_CONFIG      8'h40
`define OFS_ENABLE_CONTROL     8'h50
`define OFS_POLARITY_CONFIG    8'h54
`define OFS_IRQ_ENABLE         8'h74
`define OFS_EVENT_GENERATE     8'h78
`define OFS_EVENT_STATUS       8'h7C
`define OFS_COMPARE_VALUE      8'h90

`define BIT_MODE_SELECT_LO     16
`define BIT_PRESCALER_LO       18
`define BIT_PRELOAD_ENABLE     4
`define BIT_OUTPUT_MODE_LO     0
`define BIT_CHANNEL_ENABLE     0
`define BIT_CHANNEL_POLARITY   0
`define BIT_TRIGGER            10
`define BIT_UPDATE             8
`define BIT_OVER_CAPTURE       4
`define BIT_CHANNEL            0

`define RESET_REGISTER         32'h0000_0000
`define COUNTER_W              16

`endif

// [logic/timer_channel_pkg.sv]
// types of the timer channel
package timer_channel_pkg;

  typedef enum logic [2:0] {
    MODE_HOLD      = 3'h0,
    MODE_MATCH_LOW = 3'h1,
    MODE_MATCH_HI  = 3'h2,
    MODE_TOGGLE    = 3'h3,
    MODE_FORCE_LOW = 3'h4,
    MODE_FORCE_HI  = 3'h5,
    MODE_PWM_ONE   = 3'h6,
    MODE_PWM_TWO   = 3'h7
  } output_mode_e;

  typedef enum logic [1:0] {
    SEL_OUTPUT   = 2'h0,
    SEL_INPUT_TI = 2'h1,
    SEL_RESERVED = 2'h2,
    SEL_INPUT_ED = 2'h3
  } channel_mode_e;

endpackage

// [logic/compare_shadow.sv]
// compare value with preload register and active shadow register
`timescale 1ns/1ps
`include "timer_channel_defs.svh"
module compare_shadow #(
  parameter int WIDTH = `COUNTER_W
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             write_i,
  input  wire logic [WIDTH-1:0] write_data_i,
  input  wire logic             preload_enable_i,
  input  wire logic             update_i,
  input  wire logic             capture_i,
  input  wire logic [WIDTH-1:0] capture_data_i,
  output logic      [WIDTH-1:0] preload_o,
  output logic      [WIDTH-1:0] active_o
);

  logic [WIDTH-1:0] next_preload;
  logic [WIDTH-1:0] next_active;

  always_comb
  begin
    next_preload = preload_o;
    next_active  = active_o;
    if (capture_i)
    begin
      next_preload = capture_data_i;
      next_active  = capture_data_i;
    end
    else if (write_i)
    begin
      next_preload = write_data_i;
      if (!preload_enable_i)
        next_active = write_data_i;
    end
    if (update_i && preload_enable_i && !capture_i)
      next_active = write_i ? write_data_i : preload_o;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      preload_o <= '0;
      active_o  <= '0;
    end
    else
    begin
      preload_o <= next_preload;
      active_o  <= next_active;
    end
  end

endmodule

// [logic/capture_edge_prescaler.sv]
// capture edge selection and event prescaler of the channel input
`timescale 1ns/1ps
module capture_edge_prescaler (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       level_i,
  input  wire logic       falling_i,
  input  wire logic       enable_i,
  input  wire logic [1:0] prescale_i,
  output logic            capture_o
);

  logic       prev_level;
  logic [2:0] event_count;
  logic       next_prev_level;
  logic [2:0] next_event_count;
  logic       next_capture;
  logic       edge_seen;
  logic [2:0] limit;

  always_comb
  begin
    next_prev_level  = level_i;
    edge_seen        = falling_i ? (prev_level & ~level_i) : (~prev_level & level_i);
    limit            = 3'((4'h1 << prescale_i) - 4'h1);
    next_event_count = event_count;
    next_capture     = 1'b0;
    if (!enable_i)
      next_event_count = 3'h0;
    else if (edge_seen)
    begin
      if (event_count >= limit)
      begin
        next_event_count = 3'h0;
        next_capture     = 1'b1;
      end
      else
        next_event_count = event_count + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      prev_level  <= 1'b0;
      event_count <= 3'h0;
      capture_o   <= 1'b0;
    end
    else
    begin
      prev_level  <= next_prev_level;
      event_count <= next_event_count;
      capture_o   <= next_capture;
    end
  end

endmodule

// [testbench/timer_channel_props.sv]
// port checks of the timer channel
`timescale 1ns/1ps
`include "timer_channel_defs.svh"
module timer_channel_checker (
  input wire logic               sys_clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [`ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               counter_wrap_i,
  input wire logic               restart_trigger_i,
  input wire logic               channel_out_en_o,
  input wire logic               capture_enable_o,
  input wire logic               update_event_o,
  input wire logic               irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped; (wb_ack_o && !wb_we_i && !(wb_adr_i inside {`OFS_INPUT_CONFIG,
    `OFS_OUTPUT_CONFIG, `OFS_ENABLE_CONTROL, `OFS_POLARITY_CONFIG, `OFS_IRQ_ENABLE,
    `OFS_EVENT_STATUS, `OFS_COMPARE_VALUE})) |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_quiet; disable iff (1'b0) rst_i |=> !(wb_ack_o || irq_o ||
    channel_out_en_o || capture_enable_o || update_event_o); endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output high after reset");
  property p_en_excl; !(channel_out_en_o && capture_enable_o); endproperty
  a_en_excl: assert property (p_en_excl)
    else $error("output and capture both on");
  property p_wrap_update; counter_wrap_i |=> update_event_o; endproperty
  a_wrap_update: assert property (p_wrap_update)
    else $error("no update after wrap");
  property p_restart_update; restart_trigger_i |=> update_event_o; endproperty
  a_restart_update: assert property (p_restart_update)
    else $error("no update after restart");
  property p_update_cause; update_event_o |-> $past(counter_wrap_i || restart_trigger_i ||
    (wb_ack_o && wb_we_i && wb_adr_i == `OFS_EVENT_GENERATE && wb_dat_i[`BIT_UPDATE]));
  endproperty
  a_update_cause: assert property (p_update_cause)
    else $error("update without cause");
  property p_cap_change; $changed(capture_enable_o) |->
    ($past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2)); endproperty
  a_cap_change: assert property (p_cap_change)
    else $error("capture enable moved alone");
  property p_out_change; $changed(channel_out_en_o) |->
    ($past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2)); endproperty
  a_out_change: assert property (p_out_change)
    else $error("output enable moved alone");
endmodule
bind timer_channel_compare_control timer_channel_checker chk (.sys_clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .counter_wrap_i,
  .restart_trigger_i, .channel_out_en_o, .capture_enable_o, .update_event_o, .irq_o);

// [testbench/test_timer_channel_compare_control.sv]
// self-checking bench of the timer channel
`timescale 1ns/1ps
`include "timer_channel_defs.svh"
module test_timer_channel_compare_control;
  logic               sys_clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0, channel_in_i = 1'b0, wb_ack_o, channel_out_o;
  logic               channel_out_en_o, capture_enable_o, update_event_o, irq_o;
  logic               counter_wrap_i, restart_trigger_i, trigger_i;
  logic [2:0]         ev = 3'h0;
  logic [`ADDR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0]         wb_sel_i = 4'h0;
  logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0]        counter_value_i = 16'h0;
  int                 fail_count = 0, checks = 0;
  assign {counter_wrap_i, restart_trigger_i, trigger_i} = ev;
  timer_channel_compare_control uut (.sys_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .counter_value_i, .counter_wrap_i,
    .restart_trigger_i, .trigger_i, .channel_in_i, .channel_out_o, .channel_out_en_o,
    .capture_enable_o, .update_event_o, .irq_o);
  always #50 sys_clk_i = ~sys_clk_i;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hF};
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge sys_clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask
  task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(what, exp, rd);
  endtask
  task automatic settle();
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic cnt(input logic [15:0] v);
    @(posedge sys_clk_i);
    counter_value_i <= v;
    settle();
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge sys_clk_i);
    ev <= v;
    @(posedge sys_clk_i);
    ev <= 3'h0;
    settle();
  endtask
  task automatic t_regs();
    logic [7:0] ofs [5] = '{`OFS_OUTPUT_CONFIG, `OFS_ENABLE_CONTROL, `OFS_POLARITY_CONFIG,
      `OFS_IRQ_ENABLE, 8'h04};
    foreach (ofs[i]) rdchk("reset value", ofs[i], 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h04, 32'h0);
    wr(`OFS_IRQ_ENABLE, 32'h501);
    rdchk("irq enable", `OFS_IRQ_ENABLE, 32'h501);
    wr(`OFS_IRQ_ENABLE, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_pwm();
    wr(`OFS_OUTPUT_CONFIG, 32'h6);
    wr(`OFS_COMPARE_VALUE, 32'd100);
    wr(`OFS_ENABLE_CONTROL, 32'h1);
    cnt(16'd50);
    check("pin pwm1 below", 1, channel_out_o);
    check("pin enable", 1, channel_out_en_o);
    cnt(16'd150);
    check("pin pwm1 above", 0, channel_out_o);
    wr(`OFS_POLARITY_CONFIG, 32'h1);
    settle();
    check("pin active low", 1, channel_out_o);
    wr(`OFS_POLARITY_CONFIG, 32'h0);
    wr(`OFS_OUTPUT_CONFIG, 32'h17);
    wr(`OFS_COMPARE_VALUE, 32'd200);
    settle();
    check("pin preload held", 1, channel_out_o);
    pulse(3'h4);
    check("pin after wrap", 0, channel_out_o);
    wr(`OFS_COMPARE_VALUE, 32'd100);
    pulse(3'h2);
    check("pin after restart", 1, channel_out_o);
    wr(`OFS_OUTPUT_CONFIG, 32'h7);
    wr(`OFS_COMPARE_VALUE, 32'd200);
    settle();
    check("pin direct write", 0, channel_out_o);
    $display("test pwm done");
  endtask
  task automatic t_match();
    logic [2:0] md [7] = '{3'h5, 3'h4, 3'h2, 3'h0, 3'h1, 3'h3, 3'h3};
    logic       ex [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++)
    begin
      cnt(16'd50);
      wr(`OFS_OUTPUT_CONFIG, {29'h0, md[i]});
      cnt(16'd200);
      check("pin match mode", ex[i], channel_out_o);
    end
    $display("test match done");
  endtask
  task automatic t_sel();
    int cap [3] = '{1, 0, 1};
    wr(`OFS_ENABLE_CONTROL, 32'h0);
    settle();
    check("pin disabled", 0, {channel_out_en_o, channel_out_o});
    for (int s = 1; s < 4; s++)
    begin
      wr(`OFS_INPUT_CONFIG, s << 16);
      wr(`OFS_ENABLE_CONTROL, 32'h1);
      wr(`OFS_INPUT_CONFIG, 32'h0);
      settle();
      check("capture enable", cap[s-1], capture_enable_o);
      check("output enable", 0, channel_out_en_o);
      channel_in_i <= s[0];
      cnt(16'(s));
      rdchk("capture", `OFS_COMPARE_VALUE, cap[s-1] ? s : 1);
      wr(`OFS_ENABLE_CONTROL, 32'h0);
      settle();
      check("capture off", 0, capture_enable_o);
    end
    $display("test select done");
  endtask
  task automatic t_irq();
    logic [31:0] bits [3] = '{32'h400, 32'h100, 32'h1};
    cnt(16'd50);
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFS_IRQ_ENABLE, 32'h0);
      wr(`OFS_EVENT_STATUS, 32'h0);
      if (i == 0)
        pulse(3'h1);
      else
        wr(`OFS_EVENT_GENERATE, bits[i]);
      settle();
      check("irq masked", 0, irq_o);
      rdchk("event flags", `OFS_EVENT_STATUS, bits[i]);
      wr(`OFS_IRQ_ENABLE, bits[i]);
      settle();
      check("irq raised", 1, irq_o);
      wr(`OFS_EVENT_STATUS, 32'h0);
      settle();
      check("irq cleared", 0, irq_o);
    end
    $display("test irq done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pwm();
    t_match();
    t_sel();
    t_irq();
    end_sim();
  end
  initial
  begin
    repeat (4000) @(posedge sys_clk_i);
    fail_count++;
    end_sim();
  end
endmodule
